// File: core/itx_block_fetch.sv
`timescale 1ns/10ps
module itx_block_fetch (
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire logic                   go,
   input  wire logic [31:0]            base,
   input  wire logic [3:0]             z,
   input  wire logic [2:0]             slot,
   output itx_pkg::mem_rd_t            rd,
   input  wire logic                   rd_ack,
   input  wire logic [31:0]            rd_data,
   output logic                        busy,
   output logic                        done,
   output logic [7:0][31:0]            words
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        busy;
      logic        done;
      logic [5:0]  cnt;   // Quadlets taken so far
      logic [5:0]  last;  // Final quadlet index
      logic [31:0] addr;  // Next read address
   } fch_t;

   fch_t fch_ff;
   fch_t nxt_fch;
   logic [31:0] buf_mem [itx_pkg::BUF_WORDS];  // Whole block held here

   // Next state: one burst of z descriptors back to back
   always_comb begin
      nxt_fch      = fch_ff;
      nxt_fch.done = 1'b0;
      if (go && !fch_ff.busy) begin  // Whole block at once
         nxt_fch.busy = 1'b1;
         nxt_fch.cnt  = 6'h00;
         nxt_fch.last = 6'({z, 2'b00} - 6'h01);
         nxt_fch.addr = base;
      end else if (fch_ff.busy && rd_ack) begin
         nxt_fch.cnt  = fch_ff.cnt + 6'h01;
         nxt_fch.addr = fch_ff.addr + 32'h0000_0004;
         if (fch_ff.cnt == fch_ff.last) begin
            nxt_fch.busy = 1'b0;
            nxt_fch.done = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fch_ff <= '0;
      end else begin
         fch_ff <= nxt_fch;
      end
   end

   // Buffer store; no reset needed for data words
   always_ff @(posedge core_clk) begin
      if (fch_ff.busy && rd_ack) begin
         buf_mem[fch_ff.cnt[4:0]] <= rd_data;
      end
   end

   // Eight quadlets from the selected descriptor onward
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         words[k] = buf_mem[5'({slot, 2'b00} + 5'(k))];
      end
   end

   assign rd.req  = fch_ff.busy;
   assign rd.addr = fch_ff.addr;
   assign busy    = fch_ff.busy;
   assign done    = fch_ff.done;

   // Done follows the final acknowledged quadlet
   a_fetch_done_end: assert property (@(posedge core_clk) disable iff (!nrst)
      fch_ff.busy && rd_ack && fch_ff.cnt == fch_ff.last
      |=> done && !busy)
      else $error("fetch did not finish on last quadlet");

endmodule : itx_block_fetch

// File: core/itx_engine.sv
`timescale 1ns/10ps
// Summary of operation
// - Opcode 8 decodes as constant store
// - Stored word is zero top, halfword bottom
// - Store goes exactly to target pointer, low address bits not cleared
// - Size 0 ends on a branch and kills the start pointer, 1-8 counts, 9-15 reserved
// - Whole block fetched in one burst
// - Pad packet up to quadlet boundary
// - Final with size zero stops fetching
// - Ended program may be extended live
// - Lost cycle follows first descriptor's pointer
// - Skip ignores branch control field
// - One block consumed per bus cycle
// - Next size learned only from branch
// - Empty final fragment sends nothing if no beat went before it
// - Status flag writes control state back
module itx_engine (
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire itx_pkg::reg_req_t      reg_req,
   output logic [31:0]                 reg_rdata,
   input  wire logic                   cycle_start,
   input  wire logic                   cycle_lost,
   input  wire logic [15:0]            cycle_stamp,
   output itx_pkg::mem_rd_t            mem_rd,
   input  wire logic                   mem_rd_ack,
   input  wire logic [31:0]            mem_rd_data,
   output itx_pkg::mem_wr_t            mem_wr,
   input  wire logic                   mem_wr_ack,
   output itx_pkg::tx_beat_t           tx
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      itx_pkg::eng_state_t st;
      logic        run;       // Software run level
      logic        wake;      // Software asked for re-check
      logic        active;
      logic        dead;
      logic [31:0] cmd_ptr;   // Start pointer with size code
      logic [31:0] blk_base;  // Current block address
      logic [3:0]  blk_z;     // Current block size
      logic [2:0]  slot;      // Descriptor within block
      logic [15:0] remain;    // Bytes left in fragment
      logic [2:0]  imm_q;     // Header quadlet index
      logic [15:0] total;     // Bytes in this packet
      logic        sent;      // Any beat this cycle
      logic        recheck;   // Fetch is a re-read of an ended block
      logic        fetch_go;
      logic        rd_req;
      logic [31:0] rd_addr;
      itx_pkg::mem_wr_t wr;
      itx_pkg::tx_beat_t tx;
      logic [31:0] rdata;
   } eng_t;

   eng_t eng_ff;
   eng_t nxt_eng;

   logic [7:0][31:0] dq;          // Quadlets from current descriptor
   itx_pkg::mem_rd_t fch_rd;      // Fetcher memory request
   logic             fch_busy;
   logic             fch_done;
   logic [15:0]      ctx_state;   // Low half of context control

   // ----------------------------------------------------------------------
   // Block fetcher
   // ----------------------------------------------------------------------
   itx_block_fetch u_fetch (
      .core_clk (core_clk),
      .nrst     (nrst),
      .go       (eng_ff.fetch_go),
      .base     (eng_ff.blk_base),
      .z        (eng_ff.blk_z),
      .slot     (eng_ff.slot),
      .rd       (fch_rd),
      .rd_ack   (mem_rd_ack),
      .rd_data  (mem_rd_data),
      .busy     (fch_busy),
      .done     (fch_done),
      .words    (dq)
   );

   // Fetcher owns the read port while busy; engine never overlaps it
   assign mem_rd = fch_busy ? fch_rd
                 : itx_pkg::mem_rd_t'{eng_ff.rd_req, eng_ff.rd_addr};
   assign mem_wr = eng_ff.wr;
   assign tx     = eng_ff.tx;
   assign reg_rdata = eng_ff.rdata;

   always_comb begin
      ctx_state = 16'h0000;
      ctx_state[itx_pkg::CC_RUN]    = eng_ff.run;
      ctx_state[itx_pkg::CC_WAKE]   = eng_ff.wake;
      ctx_state[itx_pkg::CC_DEAD]   = eng_ff.dead;
      ctx_state[itx_pkg::CC_ACTIVE] = eng_ff.active;
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [3:0]  cmd;
      logic [2:0]  key;
      logic [31:0] ptr;
      logic        wake_use;
      nxt_eng          = eng_ff;
      cmd              = dq[itx_pkg::Q_CTRL][itx_pkg::CMD_HI:itx_pkg::CMD_LO];
      key              = dq[itx_pkg::Q_CTRL][itx_pkg::KEY_HI:itx_pkg::KEY_LO];
      ptr              = dq[itx_pkg::Q_BRANCH];
      wake_use         = 1'b0;
      nxt_eng.fetch_go = 1'b0;
      nxt_eng.tx.valid = 1'b0;
      nxt_eng.tx.eop   = 1'b0;
      nxt_eng.rdata    = 32'h0000_0000;

      // Register reads: answer in the next cycle only
      if (reg_req.rd) begin
         case (reg_req.addr)
            itx_pkg::REG_CTRL: nxt_eng.rdata = {16'h0000, ctx_state};
            itx_pkg::REG_PTR:  nxt_eng.rdata = eng_ff.cmd_ptr;
            itx_pkg::REG_STAT: nxt_eng.rdata = {12'h000, eng_ff.st,
                                                eng_ff.total};
            default:           nxt_eng.rdata = 32'h0000_0000;
         endcase
      end

      case (eng_ff.st)
         // Wait for run, then load the start block
         itx_pkg::S_IDLE: begin
            nxt_eng.active = 1'b0;
            if (eng_ff.run) begin
               nxt_eng.blk_base = {eng_ff.cmd_ptr[31:4], 4'h0};
               nxt_eng.blk_z    = eng_ff.cmd_ptr[3:0];
               nxt_eng.recheck  = 1'b0;
               if (itx_pkg::z_ok(eng_ff.cmd_ptr[3:0])) begin
                  nxt_eng.fetch_go = 1'b1;
                  nxt_eng.active   = 1'b1;
                  nxt_eng.st       = itx_pkg::S_FETCH;
               end else begin
                  nxt_eng.st = itx_pkg::S_DEAD;
               end
            end
         end
         itx_pkg::S_FETCH: begin
            nxt_eng.slot = 3'h0;
            if (fch_done) begin
               nxt_eng.slot = eng_ff.recheck ? 3'(eng_ff.blk_z - 4'h1)
                                             : 3'h0;
               nxt_eng.st   = eng_ff.recheck ? itx_pkg::S_BRANCH
                                             : itx_pkg::S_WAIT_CYC;
            end
         end
         // Block stays parked until its own bus cycle
         itx_pkg::S_WAIT_CYC: begin
            nxt_eng.total = 16'h0000;
            nxt_eng.sent  = 1'b0;
            if (!eng_ff.run) begin
               nxt_eng.st = itx_pkg::S_IDLE;
            end else if (cycle_lost) begin
               // First descriptor's pointer, branch code not looked at
               nxt_eng.st = itx_pkg::S_BRANCH;
            end else if (cycle_start) begin
               nxt_eng.st = itx_pkg::S_DECODE;
            end
         end
         itx_pkg::S_DECODE: begin
            nxt_eng.remain = dq[itx_pkg::Q_CTRL][itx_pkg::CNT_HI:0];
            nxt_eng.imm_q  = itx_pkg::Q_IMM;
            nxt_eng.rd_addr = dq[itx_pkg::Q_ADDR];
            if (cmd == itx_pkg::CMD_STORE) begin
               nxt_eng.wr.req  = 1'b1;
               nxt_eng.wr.addr = dq[itx_pkg::Q_ADDR];
               nxt_eng.wr.data = {16'h0000,
                                  dq[itx_pkg::Q_CTRL][15:0]};
               nxt_eng.st      = itx_pkg::S_STORE;
            end else if (key == itx_pkg::KEY_IMM) begin
               nxt_eng.st = itx_pkg::S_IMM;
            end else begin
               nxt_eng.st = itx_pkg::S_PAYLOAD;
            end
         end
         // Hold the write until memory takes it
         itx_pkg::S_STORE: begin
            if (mem_wr_ack) begin
               nxt_eng.wr.req = 1'b0;
               nxt_eng.slot   = eng_ff.slot + 3'h1;
               nxt_eng.st     = itx_pkg::S_DECODE;
            end
         end
         // Header quadlets straight from the descriptor, payload quadlets from memory
         itx_pkg::S_IMM, itx_pkg::S_PAYLOAD: begin
            if (eng_ff.remain == 16'h0000) begin
               if (cmd == itx_pkg::CMD_LAST) begin
                  // Nothing sent means a non-transmit cycle
                  nxt_eng.tx.eop = eng_ff.sent;
                  nxt_eng.wr.addr = eng_ff.blk_base
                     + {25'h0, eng_ff.slot, 4'h0} + itx_pkg::STAT_OFS;
                  nxt_eng.wr.data = {ctx_state, cycle_stamp};
                  nxt_eng.wr.req  = dq[itx_pkg::Q_CTRL][itx_pkg::STAT_BIT];
                  nxt_eng.st = dq[itx_pkg::Q_CTRL][itx_pkg::STAT_BIT]
                             ? itx_pkg::S_STATUS : itx_pkg::S_BRANCH;
               end else begin
                  nxt_eng.slot = eng_ff.slot
                     + ((eng_ff.st == itx_pkg::S_IMM) ? 3'h2 : 3'h1);
                  nxt_eng.st   = itx_pkg::S_DECODE;
               end
            end else if (eng_ff.st == itx_pkg::S_IMM ||
                         (eng_ff.rd_req && mem_rd_ack)) begin
               nxt_eng.rd_req   = 1'b0;
               nxt_eng.tx.valid = 1'b1;
               nxt_eng.tx.data  = (eng_ff.st == itx_pkg::S_IMM)
                                ? dq[eng_ff.imm_q] : mem_rd_data;
               // Bytes past the count go out as zero padding
               if (eng_ff.remain < 16'h0004) begin
                  for (int b = 0; b < 4; b++) begin
                     if (16'(b) >= eng_ff.remain) begin
                        nxt_eng.tx.data[8*b +: 8] = 8'h00;
                     end
                  end
                  nxt_eng.remain = 16'h0000;
               end else begin
                  nxt_eng.remain = eng_ff.remain - 16'h0004;
               end
               nxt_eng.total   = eng_ff.total + ((eng_ff.remain < 16'h0004)
                               ? eng_ff.remain : 16'h0004);
               nxt_eng.sent    = 1'b1;
               nxt_eng.imm_q   = eng_ff.imm_q + 3'h1;
               nxt_eng.rd_addr = eng_ff.rd_addr + 32'h0000_0004;
            end else begin
               nxt_eng.rd_req = 1'b1;
            end
         end
         itx_pkg::S_STATUS: begin
            if (mem_wr_ack) begin
               nxt_eng.wr.req = 1'b0;
               nxt_eng.st     = itx_pkg::S_BRANCH;
            end
         end
         // Size of next block comes only from this pointer
         itx_pkg::S_BRANCH: begin
            if (ptr[3:0] == itx_pkg::Z_END) begin
               nxt_eng.st = itx_pkg::S_ENDED;
            end else if (!itx_pkg::z_ok(ptr[3:0])) begin
               nxt_eng.st = itx_pkg::S_DEAD;
            end else begin
               nxt_eng.blk_base = {ptr[31:4], 4'h0};
               nxt_eng.blk_z    = ptr[3:0];
               nxt_eng.recheck  = 1'b0;
               nxt_eng.fetch_go = 1'b1;
               nxt_eng.st       = itx_pkg::S_FETCH;
            end
         end
         // Re-read the final block on wake to see appended work
         itx_pkg::S_ENDED: begin
            if (!eng_ff.run) begin
               nxt_eng.st = itx_pkg::S_IDLE;
            end else if (eng_ff.wake) begin
               wake_use         = 1'b1;
               nxt_eng.recheck  = 1'b1;
               nxt_eng.fetch_go = 1'b1;
               nxt_eng.st       = itx_pkg::S_FETCH;
            end
         end
         itx_pkg::S_DEAD: begin
            nxt_eng.dead   = 1'b1;
            nxt_eng.active = 1'b0;
            if (!eng_ff.run) begin
               nxt_eng.dead = 1'b0;
               nxt_eng.st   = itx_pkg::S_IDLE;
            end
         end
         default: nxt_eng.st = itx_pkg::S_IDLE;
      endcase

      // Register writes; a new wake beats its own consumption
      nxt_eng.wake = (eng_ff.wake && !wake_use)
                   || (reg_req.wr && reg_req.addr == itx_pkg::REG_CTRL
                       && reg_req.wdata[itx_pkg::CTL_WAKE]);
      if (reg_req.wr && reg_req.addr == itx_pkg::REG_CTRL) begin
         nxt_eng.run = reg_req.wdata[itx_pkg::CTL_RUN];
      end
      if (reg_req.wr && reg_req.addr == itx_pkg::REG_PTR) begin
         nxt_eng.cmd_ptr = reg_req.wdata;
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         eng_ff    <= '0;
         eng_ff.st <= itx_pkg::S_IDLE;
      end else begin
         eng_ff <= nxt_eng;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_store_zero_top: assert property (@(posedge core_clk) disable iff (!nrst)
      eng_ff.st == itx_pkg::S_DECODE && dq[0][31:28] == itx_pkg::CMD_STORE
      |=> mem_wr.req && mem_wr.data[31:16] == 16'h0000
          && mem_wr.data[15:0] == $past(dq[0][15:0]))
      else $error("store data not zero extended");
   a_store_target: assert property (@(posedge core_clk) disable iff (!nrst)
      eng_ff.st == itx_pkg::S_DECODE && dq[0][31:28] == itx_pkg::CMD_STORE
      |=> mem_wr.addr == $past(dq[1]))
      else $error("store address differs from target pointer");
   a_store_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      eng_ff.st == itx_pkg::S_STORE && !mem_wr_ack
      |=> eng_ff.st == itx_pkg::S_STORE && mem_wr.req)
      else $error("store left before acknowledge");
   a_reserved_size: assert property (@(posedge core_clk) disable iff (!nrst)
      eng_ff.st == itx_pkg::S_BRANCH && dq[2][3:0] > itx_pkg::Z_MAX
      |=> eng_ff.st == itx_pkg::S_DEAD ##1 tx.valid == 1'b0)
      else $error("reserved size code not refused");
   a_end_no_fetch: assert property (@(posedge core_clk) disable iff (!nrst)
      eng_ff.st == itx_pkg::S_BRANCH && dq[2][3:0] == itx_pkg::Z_END
      |=> eng_ff.st == itx_pkg::S_ENDED && !eng_ff.fetch_go)
      else $error("fetch after end of program");
   a_wake_refetch: assert property (@(posedge core_clk) disable iff (!nrst)
      eng_ff.st == itx_pkg::S_ENDED && eng_ff.run && eng_ff.wake
      |=> eng_ff.fetch_go && eng_ff.recheck ##1 fch_busy)
      else $error("wake did not re-read ended block");
   a_lost_skip: assert property (@(posedge core_clk) disable iff (!nrst)
      eng_ff.st == itx_pkg::S_WAIT_CYC && eng_ff.run && cycle_lost
      |=> eng_ff.st == itx_pkg::S_BRANCH && eng_ff.slot == 3'h0
          && !tx.valid)
      else $error("lost cycle did not skip");
   a_pad_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      tx.valid && $past(eng_ff.remain) == 16'h0001
      |-> tx.data[31:8] == 24'h000000)
      else $error("padding bytes not zero");
   a_empty_silent: assert property (@(posedge core_clk) disable iff (!nrst)
      eng_ff.st == itx_pkg::S_PAYLOAD && eng_ff.remain == 16'h0000
      && dq[0][31:28] == itx_pkg::CMD_LAST && !eng_ff.sent
      |=> !tx.eop && !tx.valid)
      else $error("empty cycle produced output");
   a_status_word: assert property (@(posedge core_clk) disable iff (!nrst)
      eng_ff.st == itx_pkg::S_STATUS
      |-> mem_wr.req && mem_wr.addr[3:0] == 4'hc)
      else $error("status write misplaced");
   a_one_block: assert property (@(posedge core_clk) disable iff (!nrst)
      eng_ff.st == itx_pkg::S_FETCH && fch_done && !eng_ff.recheck
      |=> eng_ff.st == itx_pkg::S_WAIT_CYC)
      else $error("block ran without waiting for cycle");

endmodule : itx_engine

// File: core/itx_pkg.sv
package itx_pkg;

   // ----------------------------------------------------------------------
   // Descriptor layout
   // ----------------------------------------------------------------------
   localparam logic [3:0] CMD_MORE   = 4'h0;  // Payload fragment
   localparam logic [3:0] CMD_LAST   = 4'h1;  // Final fragment
   localparam logic [3:0] CMD_STORE  = 4'h8;  // Constant store
   localparam logic [2:0] KEY_PLAIN  = 3'h0;  // Data taken from buffer
   localparam logic [2:0] KEY_IMM    = 3'h1;  // Header held in descriptor
   localparam logic [2:0] KEY_STORE  = 3'h6;  // Variant of constant store
   localparam int         CMD_HI     = 31;    // Opcode field
   localparam int         CMD_LO     = 28;
   localparam int         STAT_BIT   = 27;    // Status write flag
   localparam int         KEY_HI     = 26;    // Variant field
   localparam int         KEY_LO     = 24;
   localparam int         CNT_HI     = 15;    // Byte request count
   localparam logic [1:0] Q_CTRL     = 2'h0;  // Quadlet of control word
   localparam logic [1:0] Q_ADDR     = 2'h1;  // Quadlet of buffer address
   localparam logic [1:0] Q_BRANCH   = 2'h2;  // Quadlet of pointer and size
   localparam logic [2:0] Q_IMM      = 3'h4;  // First header quadlet
   localparam logic [3:0] Z_END      = 4'h0;  // End of program
   localparam logic [3:0] Z_MAX      = 4'h8;  // Largest block
   localparam int         BUF_WORDS  = 32;    // Eight descriptors of four
   localparam logic [31:0] STAT_OFS  = 32'h0000_000c; // Status quadlet

   // ----------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_PTR    = 8'h04;
   localparam logic [7:0] REG_STAT   = 8'h08;
   localparam int         CTL_RUN    = 0;     // Write bit: run level
   localparam int         CTL_WAKE   = 1;     // Write bit: wake pulse
   localparam int         CC_RUN     = 15;    // Context control positions
   localparam int         CC_WAKE    = 12;
   localparam int         CC_DEAD    = 11;
   localparam int         CC_ACTIVE  = 10;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE, S_FETCH, S_WAIT_CYC, S_DECODE, S_STORE, S_IMM,
      S_PAYLOAD, S_STATUS, S_BRANCH, S_ENDED, S_DEAD
   } eng_state_t;

   typedef struct packed {
      logic        req;
      logic [31:0] addr;
   } mem_rd_t;

   typedef struct packed {
      logic        req;
      logic [31:0] addr;
      logic [31:0] data;
   } mem_wr_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] data;
      logic        eop;
   } tx_beat_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } reg_req_t;

   // Block size code that names a real block
   function automatic logic z_ok(input logic [3:0] z);
      z_ok = (z != Z_END) && (z <= Z_MAX);
   endfunction : z_ok

endpackage : itx_pkg

// File: tb/itx_engine_tb_top.sv
`timescale 1ns/10ps
module itx_engine_tb_top;
   logic core_clk, nrst, cyc_st, cyc_lo, slow, rd_ack, wr_ack;
   logic [31:0] rd_data, reg_rdata, r, bd [8];
   itx_pkg::reg_req_t reg_req;
   itx_pkg::mem_rd_t  mem_rd;
   itx_pkg::mem_wr_t  mem_wr;
   itx_pkg::tx_beat_t tx;
   int error_cnt = 0, compares = 0, nb = 0, ne = 0;
   itx_engine i_itx_engine (.core_clk(core_clk), .nrst(nrst),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .cycle_start(cyc_st),
      .cycle_lost(cyc_lo), .cycle_stamp(16'h0abc), .mem_rd(mem_rd),
      .mem_rd_ack(rd_ack), .mem_rd_data(rd_data), .mem_wr(mem_wr),
      .mem_wr_ack(wr_ack), .tx(tx));
   itx_host_mem i_itx_host_mem (.core_clk(core_clk), .slow(slow),
      .rd(mem_rd), .rd_ack(rd_ack), .rd_data(rd_data), .wr(mem_wr),
      .wr_ack(wr_ack));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Beat and end-of-packet log
   always @(posedge core_clk) begin
      if (tx.valid === 1'b1 && nb < 8) bd[nb] = tx.data;
      if (tx.valid === 1'b1) nb++;
      if (tx.eop === 1'b1) ne++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict;
      $display("errors=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   // Register bus: one-cycle strobes, read data one cycle later
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk) reg_req <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk) reg_req <= '0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a);
      @(posedge core_clk) reg_req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge core_clk) reg_req <= '0;
      #1 r = reg_rdata;
   endtask : rreg
   task automatic pulse(input logic lost);
      @(posedge core_clk) {cyc_lo, cyc_st} <= {lost, ~lost};
      @(posedge core_clk) {cyc_lo, cyc_st} <= 2'b00;
   endtask : pulse
   // Store, header, padded payload, status write-back
   task automatic t_packet;
      int i;
      wreg(itx_pkg::REG_PTR, 32'h0000_0104); // Block of four
      wreg(itx_pkg::REG_CTRL, 32'h0000_0001);
      repeat (100) @(posedge core_clk);
      pulse(1'b0);
      for (i = 0; i < 500 && ne == 0; i++) @(posedge core_clk);
      if (ne == 0) begin
         chk(32'h0, 32'h1);
         give_verdict();
      end
      repeat (20) @(posedge core_clk);
      chk(i_itx_host_mem.m[12'h80], 32'h0000_1234);
      chk(bd[0], 32'h1111_2222);
      chk(bd[1], 32'h3333_4444);
      chk(bd[2], 32'haabb_ccdd);
      chk(nb, 4);
      chk(bd[3], 32'h0000_0088);
      chk(i_itx_host_mem.m[12'h4f], 32'h8400_0abc);
   endtask : t_packet
   // Appended program, lost cycle, then a non-transmit block
   task automatic t_extend;
      i_itx_host_mem.m[12'h4e] = 32'h0000_0181; // Branch to B
      wreg(itx_pkg::REG_CTRL, 32'h0000_0003);
      repeat (100) @(posedge core_clk);
      pulse(1'b1);
      repeat (60) @(posedge core_clk);
      pulse(1'b0);
      repeat (100) @(posedge core_clk);
      chk(nb, 4);
      chk(ne, 1);
   endtask : t_extend
   // Reserved size code stops the context
   task automatic t_dead;
      wreg(itx_pkg::REG_CTRL, 32'h0);
      wreg(itx_pkg::REG_PTR, 32'h0000_0109);
      wreg(itx_pkg::REG_CTRL, 32'h0000_0001);
      repeat (20) @(posedge core_clk);
      rreg(itx_pkg::REG_CTRL);
      chk(r[itx_pkg::CC_DEAD], 1'b1);
      @(posedge core_clk) #1 chk(reg_rdata, 32'h0);
      // Reserved size met on a branch rather than at start
      i_itx_host_mem.m[12'h72] = 32'h0000_0109;
      wreg(itx_pkg::REG_CTRL, 32'h0);
      wreg(itx_pkg::REG_PTR, 32'h0000_01c1);
      wreg(itx_pkg::REG_CTRL, 32'h0000_0001);
      repeat (40) @(posedge core_clk);
      pulse(1'b0);
      repeat (20) @(posedge core_clk);
      rreg(itx_pkg::REG_CTRL);
      chk(r[itx_pkg::CC_DEAD], 1'b1);
      chk(ne, 1);
   endtask : t_dead
   initial begin
      {nrst, cyc_st, cyc_lo, slow, reg_req} = '0;
      for (int k = 0; k < 1024; k++) i_itx_host_mem.m[k] = 32'h0;
      // Store first, variant six
      i_itx_host_mem.m[12'h40] = 32'h8600_1234;
      i_itx_host_mem.m[12'h41] = 32'h0000_0200;
      // Immediate header of eight bytes
      i_itx_host_mem.m[12'h44] = 32'h0100_0008;
      i_itx_host_mem.m[12'h48] = 32'h1111_2222;
      i_itx_host_mem.m[12'h49] = 32'h3333_4444;
      // Final with status, five bytes, ends program
      i_itx_host_mem.m[12'h4c] = 32'h180c_0005;
      i_itx_host_mem.m[12'h4d] = 32'h0000_0300;
      i_itx_host_mem.m[12'hc0] = 32'haabb_ccdd;
      i_itx_host_mem.m[12'hc1] = 32'h5566_7788; // Bytes past count
      i_itx_host_mem.m[12'h60] = 32'h100c_0004; // B, skipped
      i_itx_host_mem.m[12'h61] = 32'h0000_0300;
      i_itx_host_mem.m[12'h62] = 32'h0000_01c1; // Lost path to C
      i_itx_host_mem.m[12'h70] = 32'h100c_0000; // C: nothing sent
      slow = 1'b1;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      t_packet();
      slow <= 1'b0;
      t_extend();
      t_dead();
      give_verdict();
   end
endmodule : itx_engine_tb_top

// File: tb/itx_host_mem.sv
`timescale 1ns/10ps
// Host memory model: word array, one word per granted cycle
module itx_host_mem (
   input  wire logic             core_clk,
   input  wire logic             slow,
   input  wire itx_pkg::mem_rd_t rd,
   output logic                  rd_ack,
   output logic [31:0]           rd_data,
   input  wire itx_pkg::mem_wr_t wr,
   output logic                  wr_ack
);
   logic [31:0] m [1024];     // Programs and buffers, built by bench
   logic        tog_ff = 1'b0; // Alternate grants when slow
   logic        ack_ff = 1'b0; // Write taken pulse
   assign wr_ack  = ack_ff;
   assign rd_ack  = rd.req & (~slow | tog_ff);
   // Idle bus shows the inverted word so a stale value never matches
   assign rd_data = rd_ack ? m[rd.addr[11:2]] : ~m[rd.addr[11:2]];
   // Plain always: the bench also loads programs into m directly
   always @(posedge core_clk) begin
      tog_ff <= ~tog_ff;
      ack_ff <= wr.req & ~ack_ff;
      // Quadlet aligned store, low address bits unused
      if (wr.req & ~ack_ff) m[wr.addr[11:2]] <= wr.data;
   end
endmodule : itx_host_mem
